// [hdl/dtc_pkg.sv]
// Purpose: shared constants, types and decode helpers for the tone digit transceiver
// Assumes: 100 MHz system clock, analog front end delivers limited square waves
// Notes:   register offsets and bit positions are used by host software too
package dtc_pkg;

  // ------------------------------------------------------------
  // clocking
  // ------------------------------------------------------------
  localparam int CLK_HZ  = 100_000_000;
  localparam int CLK_NS  = 10;
  localparam int XTAL_HZ = 3_579_545;  // crystal rate that gates the core clock

  // ------------------------------------------------------------
  // register port
  // ------------------------------------------------------------
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] A_DATA = 3'h0;
  localparam logic [ADDR_W-1:0] A_CTRL = 3'h1;
  localparam logic [ADDR_W-1:0] A_STAT = 3'h2;
  localparam logic [ADDR_W-1:0] A_MASK = 3'h3;

  localparam int C_IRQ_MODE = 0;
  localparam int C_MON_MODE = 1;
  localparam int C_RX_SLEEP = 2;
  localparam int C_TX_SLEEP = 3;
  localparam int C_BUS_RW   = 4;
  localparam int CTRL_W     = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;

  localparam int S_TX_DONE = 0;
  localparam int S_RX_FULL = 2;
  localparam int S_DSTEER  = 3;
  localparam logic [3:0] STICKY   = 4'h5;
  localparam logic [3:0] MASK_RST = 4'h5;

  // ------------------------------------------------------------
  // tone measurement and timing
  // ------------------------------------------------------------
  localparam int LO_HZ [4] = '{697, 770, 852, 941};
  localparam int HI_HZ [4] = '{1209, 1336, 1477, 1633};
  localparam int TOL_PM     = 20;
  localparam int AVG_N      = 4;
  localparam int CNT_W      = 18;
  localparam int SETTLE_NS  = 200;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int BURST_NS   = 50_000_000;
  localparam int PAUSE_NS   = 50_000_000;
  localparam int SYNC_W     = 8;

  typedef enum logic [2:0] {
    RX_FREE   = 3'b001,
    RX_SETTLE = 3'b010,
    RX_HELD   = 3'b100
  } dtc_rx_t;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b001,
    TX_BURST = 3'b010,
    TX_PAUSE = 3'b100
  } dtc_tx_t;

  // period in clock cycles of a tone, widened or narrowed by pm per mille
  function automatic int dtc_period(input int hz, input int pm);
    return (CLK_HZ / hz) * (1000 + pm) / 1000;
  endfunction

  // row and column index to digit code [R12]
  function automatic logic [3:0] dtc_digit(input logic [1:0] row, input logic [1:0] col);
    unique case ({row, col})
      4'h0: dtc_digit = 4'h1;
      4'h1: dtc_digit = 4'h2;
      4'h2: dtc_digit = 4'h3;
      4'h3: dtc_digit = 4'hd;
      4'h4: dtc_digit = 4'h4;
      4'h5: dtc_digit = 4'h5;
      4'h6: dtc_digit = 4'h6;
      4'h7: dtc_digit = 4'he;
      4'h8: dtc_digit = 4'h7;
      4'h9: dtc_digit = 4'h8;
      4'ha: dtc_digit = 4'h9;
      4'hb: dtc_digit = 4'hf;
      4'hc: dtc_digit = 4'hb;
      4'hd: dtc_digit = 4'ha;
      4'he: dtc_digit = 4'hc;
      4'hf: dtc_digit = 4'h0;
    endcase
  endfunction

endpackage

// [hdl/dtc_sync.sv]
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: inputs are quasi-static levels relative to sys_clk
// Notes:   only the second stage leaves this module
`timescale 1ns/1ps
`default_nettype none
module dtc_sync #(
  parameter int W = 1  // bits to synchronise
) (
  input  wire logic         sys_clk,  // system clock
  input  wire logic         resetn,   // async reset, active low
  input  wire logic [W-1:0] d_in,     // raw pin levels
  output logic      [W-1:0] d_sync    // synchronised levels
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } dtc_sync_t;

  dtc_sync_t s;
  dtc_sync_t next_s;

  always_comb begin
    next_s      = s;
    next_s.meta = d_in;
    next_s.sync = s.meta;
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign d_sync = s.sync;
endmodule
`default_nettype wire

// [hdl/dtc_tone_meter.sv]
// Purpose: measure one group's tone by period counting and average over periods
// Assumes: sq_in is already synchronised
// Notes:   valid drops at the first period that misses or at a missing edge
`timescale 1ns/1ps
`default_nettype none
module dtc_tone_meter #(
  parameter bit HIGH = 1'b0  // selects the column frequency table
) (
  input  wire logic       sys_clk,  // system clock
  input  wire logic       resetn,   // async reset, active low
  input  wire logic       enable,   // receiver listening
  input  wire logic       sq_in,    // limited tone
  output logic            valid,    // tone held for the averaging span
  output logic      [1:0] idx       // index of the held tone
);
  import dtc_pkg::*;

  typedef struct packed {
    logic             prev;
    logic [CNT_W-1:0] cnt;
    logic [2:0]       run;
    logic [1:0]       idx;
    logic             valid;
  } dtc_meter_t;

  localparam logic [CNT_W-1:0] CNT_MAX =
    CNT_W'(dtc_period(HIGH ? HI_HZ[0] : LO_HZ[0], TOL_PM) + 1);

  dtc_meter_t s;
  dtc_meter_t next_s;

  // tone window lookup: {hit, index}
  function automatic logic [2:0] classify(input logic [CNT_W-1:0] c);
    classify = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (c >= CNT_W'(dtc_period(HIGH ? HI_HZ[i] : LO_HZ[i], -TOL_PM)) &&
          c <= CNT_W'(dtc_period(HIGH ? HI_HZ[i] : LO_HZ[i], TOL_PM))) begin
        classify = {1'b1, 2'(i)};
      end
    end
  endfunction

  always_comb begin
    logic [2:0] hit;
    hit         = classify(s.cnt);
    next_s      = s;
    next_s.prev = sq_in;
    if (!enable) begin
      next_s = '0;
    end else if (sq_in && !s.prev) begin
      next_s.cnt = CNT_W'(1);
      if (!hit[2]) begin  // [R13]
        next_s.run = 3'h0;
      end else if (hit[1:0] != s.idx || s.run == 3'h0) begin
        next_s.idx = hit[1:0];
        next_s.run = 3'h1;
      end else if (s.run != 3'(AVG_N)) begin
        next_s.run = s.run + 3'h1;
      end
    end else if (s.cnt == CNT_MAX) begin
      next_s.run = 3'h0;
    end else begin
      next_s.cnt = s.cnt + CNT_W'(1);
    end
    next_s.valid = enable && next_s.run == 3'(AVG_N);  // [R13]
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign valid = s.valid;
  assign idx   = s.idx;
endmodule
`default_nettype wire

// [hdl/dtc_top.sv]
// Purpose: control logic of a dual-tone digit transceiver
// Assumes: analog filters deliver limited tones; RC network sits behind the steer pin
// Notes:   tone synthesis itself is analog; this block times bursts and gates pins
//
// Operation
// [R1] interrupt mode: pin pulls low after a burst is sent or a digit received
// [R2] monitor mode: pin follows the in-band limited input as a square wave
// [R3] sleep pin high: oscillator stops, interrupt, tone and bus pins float
// [R4] sleep pin has no pull-down; system holds it low when unused
// [R5] bus floats while chip select high, or strobe inactive per bus style
// [R6] early detect rises with a valid pair, falls at once when lost
// [R7] steer rising latches the pair; steer low frees for a new pair
// [R8] guard output resets the RC; level from early detect and steer
// [R9] receiver sleep bit powers down receiver only
// [R10] transmitter sleep bit powers down transmitter and floats tone pin
// [R11] both sleep bits: shared circuits, oscillator, reference and pins off
// [R12] four-bit digit code table over rows and columns
// [R13] tones measured by counting, matched with tolerance, averaged over periods
// [R14] core clock gated by the crystal oscillator enable
// [R15] after the latch settles, delayed steering flag sets and interrupt follows
// [R16] receive-full bit and interrupt clear when status is read
// [R17] steer and bus strobes synchronised before use
// [R18] leaving sleep restarts idle with no stale interrupt
`timescale 1ns/1ps
`default_nettype none
module dtc_top #(
  parameter int BURST_CYC = dtc_pkg::BURST_NS / dtc_pkg::CLK_NS,  // tone burst length
  parameter int PAUSE_CYC = dtc_pkg::PAUSE_NS / dtc_pkg::CLK_NS   // pause after burst
) (
  input  wire logic                       sys_clk,                      // system clock
  input  wire logic                       resetn,                       // async reset
  input  wire logic [dtc_pkg::ADDR_W-1:0] reg_addr,                     // register address
  input  wire logic [dtc_pkg::DATA_W-1:0] reg_wdata,                    // write data
  input  wire logic                       reg_wr,                       // write strobe
  input  wire logic                       reg_rd,                       // read strobe
  output logic      [dtc_pkg::DATA_W-1:0] reg_rdata,                    // read data
  output logic                            irq,                          // level interrupt
  input  wire logic                       full_sleep_pin,               // sleep pin
  input  wire logic                       host_cs_n,                    // chip select
  input  wire logic                       strobe_data,                  // data or read strobe
  input  wire logic                       host_rw,                      // read/write line
  output logic      [3:0]                 host_nibble_bus_out,          // bus drive value
  output logic                            host_nibble_bus_oe,           // bus driven
  input  wire logic                       tone_lo_in,                   // row tone, limited
  input  wire logic                       tone_hi_in,                   // column tone
  input  wire logic                       mon_tone_in,                  // monitor filter out
  output logic                            early_pair_detect,            // valid pair seen
  input  wire logic                       steer_in_guard_out_in,        // steer above level
  output logic                            steer_in_guard_out_out,       // guard drive
  output logic                            steer_in_guard_out_oe,        // guard driven
  output logic                            irq_or_tone_monitor_out_out,  // open drain low
  output logic                            irq_or_tone_monitor_out_oe,   // pulls pin low
  output logic                            tone_oe,                      // tone driver live
  output logic      [3:0]                 tone_code,                    // digit being sent
  output logic                            osc_run,                      // oscillator enable
  output logic                            vref_run,                     // reference enable
  output logic                            rx_run,                       // receiver powered
  output logic                            tx_run                        // transmitter powered
);
  import dtc_pkg::*;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [3:0]        mask;
    logic [3:0]        stat;
    logic [3:0]        rx_data;
    logic [3:0]        tx_data;
    dtc_rx_t           rx_st;
    dtc_tx_t           tx_st;
    logic [7:0]        settle;
    logic [31:0]       tx_cnt;
    logic [DATA_W-1:0] rdata;
    logic              irq;
    logic              nib_oe;
    logic              early;
    logic              guard;
    logic              guard_oe;
    logic              mon_oe;
    logic              tone_oe;
    logic              osc;
    logic              rx_run;
    logic              tx_run;
    logic              steer_prev;
  } dtc_state_t;

  dtc_state_t s;
  dtc_state_t next_s;

  // ------------------------------------------------------------
  // pin synchronisers and tone meters
  // ------------------------------------------------------------
  logic [SYNC_W-1:0] syn;
  logic              sleep_s;
  logic              steer_s;
  logic              cs_s;
  logic              strobe_s;
  logic              rw_s;
  logic              lo_s;
  logic              hi_s;
  logic              mon_s;
  logic              lo_v;
  logic              hi_v;
  logic [1:0]        lo_idx;
  logic [1:0]        hi_idx;

  // sleep pin relies upon the system holding it low when unused [R4]
  dtc_sync #(.W(SYNC_W)) u_sync (  // [R17]
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .d_in    ({mon_tone_in, tone_hi_in, tone_lo_in, host_rw, strobe_data, host_cs_n,
                steer_in_guard_out_in, full_sleep_pin}),
    .d_sync  (syn)
  );
  assign {mon_s, hi_s, lo_s, rw_s, strobe_s, cs_s, steer_s, sleep_s} = syn;

  logic sleep_all;
  logic rx_off;
  logic tx_off;
  logic mon_live;
  logic meter_en;
  logic pair;
  logic rd_stat;
  logic [3:0] digit;

  assign sleep_all = sleep_s | (s.ctrl[C_RX_SLEEP] & s.ctrl[C_TX_SLEEP]);  // [R3] [R11]
  assign rx_off    = sleep_all | s.ctrl[C_RX_SLEEP];                        // [R9]
  assign tx_off    = sleep_all | s.ctrl[C_TX_SLEEP];                        // [R10]
  assign mon_live  = s.ctrl[C_MON_MODE] & ~rx_off;
  assign meter_en  = ~rx_off & ~s.ctrl[C_MON_MODE];
  assign pair      = lo_v & hi_v;
  assign rd_stat   = reg_rd && reg_addr == A_STAT;
  assign digit     = dtc_digit(lo_idx, hi_idx);                             // [R12]

  dtc_tone_meter #(.HIGH(1'b0)) u_lo (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .enable  (meter_en),
    .sq_in   (lo_s),
    .valid   (lo_v),
    .idx     (lo_idx)
  );

  dtc_tone_meter #(.HIGH(1'b1)) u_hi (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .enable  (meter_en),
    .sq_in   (hi_s),
    .valid   (hi_v),
    .idx     (hi_idx)
  );

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    logic pend;
    pend   = 1'b0;
    next_s = s;

    // register writes, status write-one-to-clear on sticky bits 0 and 2 only
    if (reg_wr && reg_addr == A_CTRL) begin
      next_s.ctrl = reg_wdata[CTRL_W-1:0];
    end
    if (reg_wr && reg_addr == A_MASK) begin
      next_s.mask = reg_wdata[3:0];
    end
    if (reg_wr && reg_addr == A_STAT) begin
      next_s.stat = s.stat & ~(reg_wdata[3:0] & STICKY);
    end
    if (rd_stat) begin
      next_s.stat[S_RX_FULL] = 1'b0;  // [R16]
    end

    // read data stands one cycle only
    next_s.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        A_DATA:  next_s.rdata = DATA_W'(s.rx_data);
        A_CTRL:  next_s.rdata = DATA_W'(s.ctrl);
        A_STAT:  next_s.rdata = DATA_W'(s.stat);
        A_MASK:  next_s.rdata = DATA_W'(s.mask);
        default: next_s.rdata = '0;
      endcase
    end

    // steering: latch at steer rise, flag after settle
    next_s.steer_prev = steer_s;
    unique case (s.rx_st)
      RX_FREE: begin
        if (steer_s && !s.steer_prev) begin
          next_s.rx_data = digit;  // [R7]
          next_s.settle  = 8'(SETTLE_CYC - 1);
          next_s.rx_st   = RX_SETTLE;
        end
      end
      RX_SETTLE: begin
        if (!steer_s) begin
          next_s.rx_st = RX_FREE;  // [R7]
        end else if (s.settle == 8'h0) begin
          next_s.stat[S_DSTEER]  = 1'b1;  // [R15]
          next_s.stat[S_RX_FULL] = 1'b1;
          next_s.rx_st           = RX_HELD;
        end else begin
          next_s.settle = s.settle - 8'h1;
        end
      end
      RX_HELD: begin
        if (!steer_s) begin
          next_s.stat[S_DSTEER] = 1'b0;
          next_s.rx_st          = RX_FREE;  // [R7]
        end
      end
    endcase

    // transmitter: burst, pause, done event
    unique case (s.tx_st)
      TX_IDLE: begin
        if (reg_wr && reg_addr == A_DATA) begin
          next_s.tx_data = reg_wdata[3:0];
          next_s.tx_cnt  = 32'(BURST_CYC - 1);
          next_s.tx_st   = TX_BURST;
        end
      end
      TX_BURST: begin
        if (s.tx_cnt == 32'h0) begin
          next_s.tx_cnt = 32'(PAUSE_CYC - 1);
          next_s.tx_st  = TX_PAUSE;
        end else begin
          next_s.tx_cnt = s.tx_cnt - 32'h1;
        end
      end
      TX_PAUSE: begin
        if (s.tx_cnt == 32'h0) begin
          next_s.stat[S_TX_DONE] = 1'b1;  // [R1]
          next_s.tx_st           = TX_IDLE;
        end else begin
          next_s.tx_cnt = s.tx_cnt - 32'h1;
        end
      end
    endcase

    // power-down overrides
    if (rx_off) begin
      next_s.rx_st          = RX_FREE;  // [R9]
      next_s.settle         = 8'h0;
      next_s.stat[S_DSTEER] = 1'b0;
    end
    if (tx_off) begin
      next_s.tx_st  = TX_IDLE;  // [R10]
      next_s.tx_cnt = 32'h0;
    end
    if (sleep_all) begin
      next_s.stat = 4'h0;  // [R18]
    end

    // pins
    pend             = |(next_s.stat & next_s.mask & STICKY);
    next_s.irq       = pend;
    next_s.early     = pair & meter_en;            // [R6]
    next_s.guard     = pair & meter_en & steer_s;  // [R8]
    next_s.guard_oe  = ~rx_off;
    next_s.tone_oe   = ~tx_off && next_s.tx_st == TX_BURST;  // [R10]
    next_s.osc       = ~sleep_all;                 // [R3] [R11] [R14]
    next_s.rx_run    = ~rx_off;                    // [R9]
    next_s.tx_run    = ~tx_off;
    if (sleep_all) begin
      next_s.mon_oe = 1'b0;  // [R3]
    end else if (mon_live) begin
      next_s.mon_oe = ~mon_s;  // [R2]
    end else begin
      next_s.mon_oe = s.ctrl[C_IRQ_MODE] & pend;  // [R1] [R15]
    end
    next_s.nib_oe = ~sleep_all && ~cs_s &&
                    (s.ctrl[C_BUS_RW] ? ~strobe_s : (strobe_s && rw_s));  // [R5]
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s       <= '0;
      s.ctrl  <= CTRL_RST;
      s.mask  <= MASK_RST;
      s.rx_st <= RX_FREE;
      s.tx_st <= TX_IDLE;
    end else begin
      s <= next_s;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign reg_rdata                   = s.rdata;
  assign irq                         = s.irq;
  assign host_nibble_bus_out         = s.rx_data;
  assign host_nibble_bus_oe          = s.nib_oe;
  assign early_pair_detect           = s.early;
  assign steer_in_guard_out_out      = s.guard;
  assign steer_in_guard_out_oe       = s.guard_oe;
  assign irq_or_tone_monitor_out_out = 1'b0;
  assign irq_or_tone_monitor_out_oe  = s.mon_oe;
  assign tone_oe                     = s.tone_oe;
  assign tone_code                   = s.tx_data;
  assign osc_run                     = s.osc;
  assign vref_run                    = s.osc;
  assign rx_run                      = s.rx_run;
  assign tx_run                      = s.tx_run;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_IRQ_PIN: assert property (  // [R1]
    (!sleep_all && !mon_live && s.ctrl[C_IRQ_MODE] && |(s.stat & s.mask & STICKY)
     && !reg_wr && !rd_stat) |=> irq_or_tone_monitor_out_oe)
    else $error("interrupt pin not pulled low while event pending");
  AST_MON_PIN: assert property (  // [R2]
    (mon_live && !sleep_all) |=> irq_or_tone_monitor_out_oe == !$past(mon_s))
    else $error("monitor pin does not follow the filtered input");
  AST_SLEEP_PIN: assert property (  // [R3]
    sleep_s |=> !(irq_or_tone_monitor_out_oe || tone_oe || host_nibble_bus_oe || osc_run))
    else $error("pins driven or oscillator running during sleep");
  AST_BUS_FLOAT: assert property (  // [R5]
    cs_s |=> !host_nibble_bus_oe)
    else $error("bus driven while chip deselected");
  AST_EARLY_DROP: assert property (  // [R6]
    (early_pair_detect && !pair) |=> !early_pair_detect)
    else $error("early detect held after pair lost");
  AST_LATCH: assert property (  // [R7]
    (s.rx_st == RX_FREE && steer_s && !s.steer_prev && !rx_off)
    |=> s.rx_data == $past(digit) && s.rx_st == RX_SETTLE)
    else $error("pair not latched at steer rise");
  AST_GUARD: assert property (  // [R8]
    steer_in_guard_out_out |-> $past(steer_s) && $past(pair))
    else $error("guard driven without steer and pair");
  AST_RX_SLEEP: assert property (  // [R9]
    s.ctrl[C_RX_SLEEP] |=> !rx_run && !early_pair_detect && s.rx_st == RX_FREE)
    else $error("receiver active while asleep");
  AST_TX_SLEEP: assert property (  // [R10]
    s.ctrl[C_TX_SLEEP] |=> !tone_oe && s.tx_st == TX_IDLE)
    else $error("tone pin driven while transmitter asleep");
  AST_BOTH_SLEEP: assert property (  // [R11]
    (s.ctrl[C_RX_SLEEP] && s.ctrl[C_TX_SLEEP])
    |=> !osc_run && !vref_run && !irq_or_tone_monitor_out_oe && !host_nibble_bus_oe)
    else $error("shared circuits alive with both sleep bits set");
  AST_DSTEER: assert property (  // [R15]
    $rose(s.stat[S_DSTEER]) |-> $past(s.rx_st) == RX_SETTLE && s.stat[S_RX_FULL])
    else $error("delayed steering rose without settle");
  AST_RD_CLEAR: assert property (  // [R16]
    (rd_stat && !(s.rx_st == RX_SETTLE && s.settle == 8'h0 && steer_s))
    |=> !s.stat[S_RX_FULL])
    else $error("receive-full not cleared by status read");
  AST_WAKE: assert property (  // [R18]
    $fell(sleep_all) |-> !irq && s.stat == 4'h0)
    else $error("stale interrupt after wake");

  COV_RX_DIGIT: cover property ($rose(s.stat[S_RX_FULL]));
  COV_TX_DONE: cover property ($rose(s.stat[S_TX_DONE]));
  COV_MON: cover property (mon_live ##1 $fell(irq_or_tone_monitor_out_oe));
  COV_SLEEP: cover property ($rose(sleep_s) ##[1:10] $fell(osc_run));
endmodule
`default_nettype wire

// [testbench/dtc_host_model.sv]
// Purpose: host side of the nibble bus; drives select and strobes
// Assumes: bench calls drive() between accesses
// Notes:   released wire shows the inverse of its last driven value
`timescale 1ns/1ps
`default_nettype none
module dtc_host_model (
  input  wire logic       sys_clk,      // system clock
  input  wire logic       bus_oe,       // device drives the bus
  input  wire logic [3:0] bus_out,      // device drive value
  output logic            host_cs_n,    // chip select
  output logic            strobe_data,  // data or read strobe
  output logic            host_rw,      // read/write line
  output logic      [3:0] bus_wire      // resolved bus level
);
  logic [3:0] last = 4'h0;
  initial begin
    host_cs_n = 1'b1;
    strobe_data = 1'b0;
    host_rw = 1'b0;
  end
  always @(posedge sys_clk) if (bus_oe) last <= bus_out;
  assign bus_wire = bus_oe ? bus_out : ~last;
  task automatic drive(input logic c, input logic s, input logic r);
    @(posedge sys_clk);
    host_cs_n <= c;
    strobe_data <= s;
    host_rw <= r;
  endtask
endmodule
`default_nettype wire

// [testbench/test_dtc_top.sv]
// Purpose: self-checking bench for the transceiver control block
// Assumes: short burst and pause counts
// Notes:   tone inputs get random noise only
`timescale 1ns/1ps
`default_nettype none
module test_dtc_top;
  import dtc_pkg::*;
  localparam int BC = 20;
  logic sys_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, sleep = 0;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, rdata;
  logic irq, bus_oe, tone_oe, osc_run, vref_run, rx_run, tx_run, cs_n, strb, rw, irq_oe;
  logic early, guard, guard_oe, od_v, steer = 0;
  logic [3:0] bus_out, wire_v, tone_code;
  logic [2:0] rnd = 3'h0, mon_hist = 3'h0;
  int n_fail = 0, samples_checked = 0;
  dtc_top #(.BURST_CYC(BC), .PAUSE_CYC(BC)) dtc_top_i (.sys_clk(sys_clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .irq(irq), .full_sleep_pin(sleep), .host_cs_n(cs_n),
    .strobe_data(strb), .host_rw(rw), .host_nibble_bus_out(bus_out),
    .host_nibble_bus_oe(bus_oe), .tone_lo_in(rnd[0]), .tone_hi_in(rnd[1]),
    .mon_tone_in(rnd[2]), .early_pair_detect(early), .steer_in_guard_out_in(steer),
    .steer_in_guard_out_out(guard), .steer_in_guard_out_oe(guard_oe),
    .irq_or_tone_monitor_out_out(od_v),
    .irq_or_tone_monitor_out_oe(irq_oe), .tone_oe(tone_oe), .tone_code(tone_code),
    .osc_run(osc_run), .vref_run(vref_run), .rx_run(rx_run), .tx_run(tx_run));
  dtc_host_model dtc_host_model_i (.sys_clk(sys_clk), .bus_oe(bus_oe), .bus_out(bus_out),
    .host_cs_n(cs_n), .strobe_data(strb), .host_rw(rw), .bus_wire(wire_v));
  initial forever #5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) rnd <= 3'($urandom);
  // monitor input as the pin logic sees it three edges later
  always @(posedge sys_clk) mon_hist <= {mon_hist[1:0], rnd[2]};
  function automatic logic exp_irq(input logic [3:0] st, input logic [3:0] mk);
    return |(st & mk & 4'h5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic tx(input logic [3:0] d, input logic m);
    wr(A_MASK, {7'h00, m});
    wr(A_DATA, {4'h0, d});
    #1 chk(tone_oe, 1'b1);
    chk(tone_code, d);
    repeat (2 * BC + 4) @(posedge sys_clk);
    #1 chk(irq, exp_irq(4'h1, {3'h0, m}));
    chk(irq_oe, m);
    rd(A_STAT, 8'h01);
    wr(A_STAT, 8'h01);
    repeat (2) @(posedge sys_clk);
    #1 chk(irq, 1'b0);
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100us;
    n_fail++;
    end_of_test();
  end
  initial begin
    void'($urandom(46));
    repeat (6) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(A_CTRL, 8'h00);
    rd(A_MASK, 8'h05);
    rd(3'h6, 8'h00);
    wr(A_CTRL, 8'h01);
    repeat (4) tx(4'($urandom), 1'($urandom));
    tx(4'h0, 1'b1);
    for (int i = 1; i < 4; i++) begin
      wr(A_CTRL, 8'(i * 4));
      repeat (3) @(posedge sys_clk);
      #1 chk(rx_run, i[0] == 0);
      chk(tx_run, i[1] == 0);
      chk(osc_run, i != 3);
      chk(vref_run, i != 3);
      chk(guard_oe, i[0] == 0);
    end
    wr(A_CTRL, 8'h09);
    wr(A_DATA, 8'h05);
    #1 chk(tone_oe, 1'b0);
    for (int s = 0; s < 2; s++) begin
      wr(A_CTRL, {3'h0, s[0], 4'h1});
      dtc_host_model_i.drive(1'b0, s == 0, 1'b1);
      repeat (4) @(posedge sys_clk);
      #1 chk(bus_oe, 1'b1);
      dtc_host_model_i.drive(1'b0, s != 0, 1'b1);
      repeat (4) @(posedge sys_clk);
      #1 chk(bus_oe, 1'b0);
    end
    wr(A_CTRL, 8'h01);
    wr(A_MASK, 8'h04);
    steer <= 1'b1;
    repeat (SETTLE_CYC + 4) @(posedge sys_clk);
    #1 chk({irq, irq_oe}, 8'h03);
    chk({early, guard, od_v, guard_oe}, 8'h01);
    chk(wire_v, 8'h01);
    rd(A_DATA, 8'h01);
    rd(A_STAT, 8'h0c);
    chk({irq, irq_oe}, 8'h00);
    rd(A_STAT, 8'h08);
    @(posedge sys_clk);
    steer <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(A_STAT, 8'h00);
    wr(A_CTRL, 8'h02);
    repeat (3) @(posedge sys_clk);
    for (int k = 0; k < 8; k++) begin
      @(posedge sys_clk);
      #1 chk(irq_oe, !mon_hist[2]);
    end
    wr(A_CTRL, 8'h01);
    sleep <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1 chk({osc_run, bus_oe, tone_oe, irq_oe}, 8'h00);
    sleep <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1 chk({osc_run, irq}, 8'h02);
    end_of_test();
  end
endmodule
`default_nettype wire
